// *** scc_pkg.sv ***
package scc_pkg;

  // Register byte addresses (index times four)
  localparam logic [9:0] OFS_IO_DIR        = 10'h15C; // 57h
  localparam logic [9:0] OFS_DEBOUNCE      = 10'h184; // 61h
  localparam logic [9:0] OFS_DOZE          = 10'h194; // 65h
  localparam logic [9:0] OFS_PMU_CTRL8     = 10'h198; // 66h
  localparam logic [9:0] OFS_SLOW_SPEED    = 10'h104; // 41h
  localparam logic [9:0] OFS_SWITCH_DELAY  = 10'h2C0; // B0h
  localparam logic [9:0] OFS_SW_COMMAND    = 10'h3F0;
  localparam logic [9:0] OFS_STATUS        = 10'h3F4;

  // Field positions
  localparam int BIT_IO3_DIR       = 3;
  localparam int BIT_REQ_ENABLE    = 2;
  localparam int BIT_REQ_LATCH     = 6;
  localparam int BIT_DOZE_STOP     = 5;
  localparam int BIT_GRANT_PIN_FN  = 3;
  localparam int BIT_GRANT_CYCLE   = 0;
  localparam int SPEED_LSB         = 2;
  localparam int SPEED_W           = 3;
  localparam int BIT_DELAY_ENABLE  = 7;
  localparam int DELAY_W           = 7;
  localparam int BIT_SW_STOP       = 0;
  localparam int BIT_SW_SLOW       = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int DELAY_UNIT_NS    = 160;
  localparam int DELAY_UNIT_CYC   = (DELAY_UNIT_NS * CLK_MHZ) / 1000;

  // Clock speed select, 3'h0 is full speed
  localparam logic [2:0] SPEED_FULL = 3'h0;
  localparam logic [2:0] SPEED_STOP = 3'h7;

  typedef enum logic [2:0] {
    SCC_IDLE    = 3'b000,
    SCC_REQ     = 3'b001,
    SCC_READY   = 3'b011,
    SCC_STOPPED = 3'b010,
    SCC_DOZEUP  = 3'b110,
    SCC_DELAY   = 3'b111
  } scc_state_e;

endpackage

// *** scc_delay_timer.sv ***
`timescale 1ns/1ps
module scc_delay_timer
  import scc_pkg::*;
#(
  parameter int UNIT_CYC = DELAY_UNIT_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic [DELAY_W-1:0] units,
  output logic                    done
);

  if (UNIT_CYC < 1) begin : g_unit_check
    $error("scc_delay_timer: UNIT_CYC must be at least 1");
  end

  typedef struct packed {
    logic [DELAY_W-1:0] left;
    logic [15:0]        tick;
    logic               busy;
    logic               done;
  } scc_tmr_s;

  scc_tmr_s r;
  scc_tmr_s next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.left = units;
      next_r.tick = 16'(UNIT_CYC - 1);
      next_r.busy = (units != '0);
      next_r.done = (units == '0);
    end else if (r.busy) begin
      if (r.tick != 16'h0000) begin
        next_r.tick = r.tick - 16'h0001;
      end else if (r.left == 7'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.left = r.left - 7'h01;
        next_r.tick = 16'(UNIT_CYC - 1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;

endmodule

// *** scc_stop_clock.sv ***
`timescale 1ns/1ps
// Functional notes
// - Handshake precedes every clock speed change when request logic is enabled
// - Answer the grant bus cycle with ready so CPU enters grant state
// - Interrupt while clock stopped restarts CPU clock at once
// - Request logic enabled only if both straps read high at reset
// - Latch bit one stops clock latched; zero pulses for slowing
// - Doze type one stops clock in doze; zero only slows it
// - Slowed doze speed comes from three-bit slowdown field
// - Request output generated only when request enable bit set
// - Grant bus cycle counts as grant only when protocol bit set
// - Shared I/O line is grant input when function set, direction input
// - Grant function without pin may give false grant; software must clear
// - Doze slows or stops CPU clock when system is idle
// - Thermal logic forces reduced speed after long full speed running
// - Doze and thermal both use the same request and grant mechanism
// - Full stop possible on software request and from doze
// - Without handshake, doze changes clock directly for static CPUs
// - Stop: request, grant, ready, stop, wake, restart, delay, release
// - Pulsed mode: speed changes after ready; request then lasts programmed delay
// - Latched wake restarts at doze speed, then full, then delayed release
// - Delay enable and value set wait before release; zero none
module scc_stop_clock
  import scc_pkg::*;
#(
  parameter int UNIT_CYC = DELAY_UNIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Straps and activity sources
  input  wire logic        strap_a,
  input  wire logic        strap_b,
  input  wire logic        doze_request,
  input  wire logic        thermal_request,
  input  wire logic        wake_event,
  // CPU side
  input  wire logic        grant_cycle,
  output logic             grant_cycle_ready,
  input  wire logic        general_io_line_three,
  output logic             cpu_halt_request_n,
  output logic [2:0]       cpu_clock_speed
);

  // Tick counter in the timer is only 16 bits wide
  if (UNIT_CYC < 1 || UNIT_CYC > 65535) begin : g_unit_check
    $error("scc_stop_clock: UNIT_CYC out of range");
  end

  typedef struct packed {
    scc_state_e  st;
    logic        strap_seen;
    logic        req_allowed;
    logic [7:0]  io_dir;
    logic [7:0]  debounce;
    logic [7:0]  doze;
    logic [7:0]  ctrl8;
    logic [7:0]  slow_speed;
    logic [7:0]  sw_delay;
    logic        sw_stop;
    logic        sw_slow;
    logic        op_stop;
    logic [2:0]  target;
    logic        bus_wait;
    logic [31:0] rdata;
    logic        ready_out;
    logic        req_n;
    logic [2:0]  speed;
    logic        tmr_start;
  } scc_s;

  scc_s r;
  scc_s next_r;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Derived controls

  logic       proto_on;
  logic       pin_grant;
  logic       granted;
  logic       want_stop;
  logic       want_slow;
  logic       stop_now;
  logic [2:0] slow_val;
  logic [6:0] delay_units;

  always_comb begin
    proto_on    = r.req_allowed && r.debounce[BIT_REQ_ENABLE];
    pin_grant   = r.ctrl8[BIT_GRANT_PIN_FN] && !r.io_dir[BIT_IO3_DIR]
                  && !general_io_line_three;
    granted     = (r.ctrl8[BIT_GRANT_CYCLE] && grant_cycle) || pin_grant;
    slow_val    = r.slow_speed[SPEED_LSB +: SPEED_W];
    want_stop   = r.sw_stop || (doze_request && r.ctrl8[BIT_DOZE_STOP]);
    want_slow   = r.sw_slow || thermal_request
                  || (doze_request && !r.ctrl8[BIT_DOZE_STOP]);
    stop_now    = want_stop && (r.doze[BIT_REQ_LATCH] || !proto_on);
    delay_units = r.sw_delay[BIT_DELAY_ENABLE] ? r.sw_delay[DELAY_W-1:0]
                                                : 7'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_r           = r;
    next_r.ready_out = 1'b0;
    next_r.tmr_start = 1'b0;

    // Straps caught on the first clock after reset release
    if (!r.strap_seen) begin
      next_r.strap_seen  = 1'b1;
      next_r.req_allowed = strap_a && strap_b;
    end

    // Every access waits one cycle so waitrequest stays a plain flop
    next_r.bus_wait = !((avs_read || avs_write) && r.bus_wait);
    if (avs_write && !r.bus_wait) begin
      case (avs_address)
        OFS_IO_DIR:       next_r.io_dir     = avs_byteenable[0] ? avs_writedata[7:0] : r.io_dir;
        OFS_DEBOUNCE:     next_r.debounce   = avs_byteenable[0] ? avs_writedata[7:0] : r.debounce;
        OFS_DOZE:         next_r.doze       = avs_byteenable[0] ? avs_writedata[7:0] : r.doze;
        OFS_PMU_CTRL8:    next_r.ctrl8      = avs_byteenable[0] ? avs_writedata[7:0] : r.ctrl8;
        OFS_SLOW_SPEED:   next_r.slow_speed = avs_byteenable[0] ? avs_writedata[7:0] : r.slow_speed;
        OFS_SWITCH_DELAY: next_r.sw_delay   = avs_byteenable[0] ? avs_writedata[7:0] : r.sw_delay;
        OFS_SW_COMMAND: begin
          if (avs_byteenable[0]) begin
            next_r.sw_stop = avs_writedata[BIT_SW_STOP];
            next_r.sw_slow = avs_writedata[BIT_SW_SLOW];
          end
        end
        default: begin
        end
      endcase
    end
    if (avs_read && r.bus_wait) begin
      case (avs_address)
        OFS_IO_DIR:       next_r.rdata = {24'h000000, r.io_dir};
        OFS_DEBOUNCE:     next_r.rdata = {24'h000000, r.debounce};
        OFS_DOZE:         next_r.rdata = {24'h000000, r.doze};
        OFS_PMU_CTRL8:    next_r.rdata = {24'h000000, r.ctrl8};
        OFS_SLOW_SPEED:   next_r.rdata = {24'h000000, r.slow_speed};
        OFS_SWITCH_DELAY: next_r.rdata = {24'h000000, r.sw_delay};
        OFS_SW_COMMAND:   next_r.rdata = {30'h00000000, r.sw_slow, r.sw_stop};
        OFS_STATUS:       next_r.rdata = {21'h000000, r.req_allowed, r.st,
                                          r.speed, 3'h0, !r.req_n};
        default:          next_r.rdata = 32'h00000000;
      endcase
    end

    case (r.st)
      SCC_IDLE: begin
        if (want_stop || want_slow) begin
          // Pulsed request cannot hold a stopped CPU, so it only slows
          next_r.op_stop = stop_now;
          next_r.target  = stop_now ? SPEED_STOP : slow_val;
          if (proto_on) begin
            next_r.req_n = 1'b0;
            next_r.st    = SCC_REQ;
          end else begin
            next_r.speed = want_stop ? SPEED_STOP : slow_val;
            next_r.st    = want_stop ? SCC_STOPPED : SCC_DELAY;
          end
        end else if (r.speed != SPEED_FULL) begin
          // Return to full speed also needs the handshake when request logic is enabled
          next_r.op_stop = 1'b0;
          next_r.target  = SPEED_FULL;
          if (proto_on) begin
            next_r.req_n = 1'b0;
            next_r.st    = SCC_REQ;
          end else begin
            next_r.speed = SPEED_FULL;
          end
        end
      end
      SCC_REQ: begin
        // Clock untouched and request held until grant
        if (granted) begin
          next_r.ready_out = grant_cycle && r.ctrl8[BIT_GRANT_CYCLE];
          next_r.st        = SCC_READY;
        end
      end
      SCC_READY: begin
        if (r.op_stop) begin
          next_r.speed = SPEED_STOP;
          next_r.st    = SCC_STOPPED;
        end else begin
          next_r.speed     = r.target;
          next_r.tmr_start = 1'b1;
          next_r.st        = SCC_DELAY;
        end
      end
      SCC_STOPPED: begin
        if (wake_event) begin
          next_r.sw_stop = 1'b0;
          next_r.speed   = slow_val;
          next_r.st      = SCC_DOZEUP;
        end
      end
      SCC_DOZEUP: begin
        next_r.speed     = SPEED_FULL;
        next_r.tmr_start = 1'b1;
        next_r.st        = SCC_DELAY;
      end
      SCC_DELAY: begin
        // Pulse mode releases after delay; latch mode same after restart
        if (tmr_done || !r.doze[BIT_REQ_LATCH] && r.req_n) begin
          next_r.req_n = 1'b1;
          next_r.st    = want_stop || want_slow ? SCC_DELAY : SCC_IDLE;
        end else if (r.req_n && !(want_stop || want_slow)) begin
          next_r.st = SCC_IDLE;
        end
      end
      default: begin
        next_r.st = SCC_IDLE;
      end
    endcase

    if (r.st == SCC_DELAY && r.req_n && !(want_stop || want_slow)) begin
      next_r.st = SCC_IDLE;
    end
    if (!proto_on && r.st == SCC_DELAY) begin
      next_r.req_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r            <= '0;
      r.st         <= SCC_IDLE;
      r.req_n      <= 1'b1;
      r.io_dir     <= RESET_BYTE;
      r.debounce   <= RESET_BYTE;
      r.doze       <= RESET_BYTE;
      r.ctrl8      <= RESET_BYTE;
      r.slow_speed <= RESET_BYTE;
      r.sw_delay   <= RESET_BYTE;
      r.speed      <= SPEED_FULL;
      r.bus_wait   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching delay

  scc_delay_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_delay (
    .clk   (clk),
    .rst   (rst),
    .start (r.tmr_start),
    .units (delay_units),
    .done  (tmr_done)
  );

  assign avs_readdata      = r.rdata;
  assign avs_waitrequest   = r.bus_wait;
  assign grant_cycle_ready = r.ready_out;
  assign cpu_halt_request_n = r.req_n;
  assign cpu_clock_speed   = r.speed;

endmodule

// *** scc_stop_clock_sva.sv ***
`timescale 1ns/1ps
module scc_stop_clock_sva
  import scc_pkg::*;
#(
  parameter int UNIT_CYC = DELAY_UNIT_CYC
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       grant_cycle,
  input wire logic       grant_cycle_ready,
  input wire logic       general_io_line_three,
  input wire logic       wake_event,
  input wire logic       cpu_halt_request_n,
  input wire logic [2:0] cpu_clock_speed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_bus_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_doze_up;
    cpu_clock_speed != SPEED_FULL ##1 cpu_clock_speed == SPEED_FULL;
  endsequence
  a_read_wait: assert property ($rose(avs_read) |-> s_bus_answer)
    else $error("read answer timing wrong");
  a_write_wait: assert property ($rose(avs_write) |-> s_bus_answer)
    else $error("write answer timing wrong");
  a_ready_pulse: assert property (grant_cycle_ready |=> !grant_cycle_ready)
    else $error("ready longer than one cycle");
  a_ready_needs_grant: assert property ($rose(grant_cycle_ready) |->
    $past(grant_cycle)) else $error("ready without grant");
  a_ready_with_req: assert property (grant_cycle_ready |-> !cpu_halt_request_n)
    else $error("ready without request");
  a_speed_on_ready: assert property (grant_cycle_ready && cpu_clock_speed == SPEED_FULL
    |=> cpu_clock_speed != SPEED_FULL) else $error("speed not changed after ready");
  a_hold_pending: assert property (!$past(cpu_halt_request_n) && !$past(grant_cycle_ready)
    && $past(general_io_line_three, 2)
    && $past(cpu_clock_speed) == SPEED_FULL |-> cpu_clock_speed == SPEED_FULL)
    else $error("speed changed without grant");
  a_wake_restart: assert property (cpu_clock_speed == SPEED_STOP && wake_event
    |-> ##[1:2] cpu_clock_speed != SPEED_STOP) else $error("no restart on wake");
  a_wake_dozeup: assert property ($past(cpu_clock_speed) == SPEED_STOP
    && cpu_clock_speed != SPEED_STOP |-> s_doze_up) else $error("restart not via doze speed");
  a_no_release_stopped: assert property ($rose(cpu_halt_request_n) |->
    $past(cpu_clock_speed) != SPEED_STOP) else $error("request released while stopped");
endmodule
bind scc_stop_clock scc_stop_clock_sva #(.UNIT_CYC(UNIT_CYC)) u_scc_stop_clock_sva (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .grant_cycle(grant_cycle),
  .grant_cycle_ready(grant_cycle_ready), .general_io_line_three(general_io_line_three),
  .wake_event(wake_event), .cpu_halt_request_n(cpu_halt_request_n),
  .cpu_clock_speed(cpu_clock_speed));

// *** scc_cpu_model.sv ***
`timescale 1ns/1ps
module scc_cpu_model #(
  parameter int LAG = 5
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cpu_halt_request_n,
  input  wire logic grant_cycle_ready,
  input  wire logic use_pin,
  output logic      grant_cycle,
  output logic      grant_pin_n
);
  int   cnt;
  logic done;
  // Pin released means pulled up, so idle reads high
  always_ff @(posedge clk or posedge rst) begin
    if (rst || cpu_halt_request_n) begin
      cnt <= 0;
      done <= 1'b0;
      grant_cycle <= 1'b0;
      grant_pin_n <= 1'b1;
    end else if (grant_cycle && grant_cycle_ready) begin
      grant_cycle <= 1'b0;
      done <= 1'b1;
    end else if (!done && cnt == LAG) begin
      if (use_pin) begin
        grant_pin_n <= 1'b0;
        done <= 1'b1;
      end else begin
        grant_cycle <= 1'b1;
      end
    end else if (!done) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** tb_scc_stop_clock.sv ***
`timescale 1ns/1ps
module tb_scc_stop_clock;
  import scc_pkg::*;
  localparam int U = 1;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, grant_cycle, grant_cycle_ready, gio, req_n, use_pin = 1'b0;
  logic        doze = 1'b0, therm = 1'b0, wake = 1'b0;
  logic [2:0]  speed;
  int          fail_count = 0, n_compared = 0, c;
  logic [9:0]  regs [7] = '{OFS_IO_DIR, OFS_DEBOUNCE, OFS_DOZE, OFS_PMU_CTRL8,
                            OFS_SLOW_SPEED, OFS_SWITCH_DELAY, 10'h000};
  always #5 clk = ~clk;
  scc_stop_clock #(.UNIT_CYC(U)) u_scc_stop_clock (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .strap_a(1'b1), .strap_b(1'b1),
    .doze_request(doze), .thermal_request(therm), .wake_event(wake),
    .grant_cycle(grant_cycle), .grant_cycle_ready(grant_cycle_ready),
    .general_io_line_three(gio), .cpu_halt_request_n(req_n), .cpu_clock_speed(speed));
  scc_cpu_model u_scc_cpu_model (.clk(clk), .rst(rst), .cpu_halt_request_n(req_n),
    .grant_cycle_ready(grant_cycle_ready), .use_pin(use_pin), .grant_cycle(grant_cycle),
    .grant_pin_n(gio));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= rd;
    avs_write <= !rd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      chk("bus answer", 1, 0);
      stop_test();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic waitv(input string nm, input logic [3:0] want, output int cyc);
    n_compared++;
    for (cyc = 0; cyc < 300; cyc++) begin
      @(negedge clk);
      if ({req_n, speed} === want) return;
    end
    chk(nm, want, {req_n, speed});
    stop_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    chk("request idle", 1, req_n);
    chk("speed idle", SPEED_FULL, speed);
    foreach (regs[i]) begin
      bus(1'b1, regs[i], 8'h00, q);
      chk("reset value", RESET_BYTE, q);
    end
    bus(1'b1, OFS_STATUS, 8'h00, q);
    chk("status", 32'h00000400, q);
    wr(OFS_SWITCH_DELAY, 8'h5A);
    bus(1'b1, OFS_SWITCH_DELAY, 8'h00, q);
    chk("read back", 32'h0000005A, q);
    $display("test reset done");
  endtask
  // Slow through handshake, from thermal or from doze
  task automatic t_slow(input logic dz, input logic [7:0] dly);
    int c2;
    wr(OFS_DEBOUNCE, 8'h04);
    wr(OFS_PMU_CTRL8, 8'h01);
    wr(OFS_DOZE, 8'h00);
    wr(OFS_SLOW_SPEED, 8'h0C);
    wr(OFS_SWITCH_DELAY, dly);
    @(posedge clk);
    if (dz) doze <= 1'b1; else therm <= 1'b1;
    waitv("pending", 4'h0, c);
    waitv("slowed", 4'h3, c);
    waitv("released", 4'hB, c2);
    if (dly[7]) chk("delay long", 1, c2 >= int'(dly[6:0]) * U - 1);
    else chk("delay none", 1, c2 <= 2);
    @(posedge clk);
    doze <= 1'b0;
    therm <= 1'b0;
    waitv("full again", 4'h8, c);
    $display("test slow done");
  endtask
  task automatic t_stop(input logic sw);
    wr(OFS_DOZE, 8'h40);
    wr(OFS_PMU_CTRL8, 8'h21);
    if (sw) wr(OFS_SW_COMMAND, 8'h01);
    else doze <= 1'b1;
    waitv("stopped", 4'h7, c);
    @(posedge clk);
    doze <= 1'b0;
    repeat (10) @(posedge clk);
    chk("stays stopped", 4'h7, {req_n, speed});
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    waitv("restarted", 4'h8, c);
    $display("test stop done");
  endtask
  task automatic t_pin;
    @(posedge clk);
    use_pin <= 1'b1;
    wr(OFS_DOZE, 8'h00);
    wr(OFS_PMU_CTRL8, 8'h08);
    wr(OFS_IO_DIR, 8'h08);
    therm <= 1'b1;
    repeat (40) @(posedge clk);
    chk("pin as output", 4'h0, {req_n, speed});
    wr(OFS_IO_DIR, 8'h00);
    waitv("pin grant", 4'h3, c);
    @(posedge clk);
    therm <= 1'b0;
    waitv("pin full", 4'h8, c);
    $display("test pin done");
  endtask
  task automatic t_off;
    wr(OFS_DEBOUNCE, 8'h00);
    therm <= 1'b1;
    repeat (30) @(posedge clk);
    chk("no request", 1, req_n);
    chk("direct slow", 3'h3, speed);
    therm <= 1'b0;
    $display("test off done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_slow(1'b0, 8'h84);
    t_slow(1'b1, 8'h00);
    t_stop(1'b0);
    t_stop(1'b1);
    t_pin();
    t_off();
    stop_test();
  end
endmodule
